/* File: rtl/crf_cfg.svh */
`ifndef CRF_CFG_SVH
`define CRF_CFG_SVH

// register port
`define CRF_ADDR_W          4
`define CRF_DATA_W          8
`define CRF_OFS_RX_FLAGS    4'h0
`define CRF_OFS_RX_IRQ_EN   4'h1
`define CRF_OFS_LIVE_STATE  4'h2

// receiver flag register fields
`define CRF_BIT_WAKE        7
`define CRF_BIT_CSC         6
`define CRF_RX_BUS_STATE_HI        5
`define CRF_RX_BUS_STATE_LO        4
`define CRF_TX_BUS_STATE_HI        3
`define CRF_TX_BUS_STATE_LO        2
`define CRF_BIT_OVR         1
`define CRF_BIT_RXF         0

// reset values
`define CRF_FLAGS_RST       8'h00
`define CRF_IRQ_EN_RST      8'h00
`define CRF_RDATA_RST       8'h00
`define CRF_PIN_RST         1'b1

// error counter thresholds
`define CRF_REC_WARN        8'h60
`define CRF_REC_ERR         8'h7F
`define CRF_TEC_WARN        9'h060
`define CRF_TEC_ERR         9'h07F
`define CRF_TEC_OFF         9'h0FF

`endif

/* File: rtl/crf_pkg.sv */
package crf_pkg;

    // bus state codes shared by the receiver and transmitter fields
    typedef enum logic [1:0] {
        CRF_ST_OK   = 2'b00,
        CRF_ST_WARN = 2'b01,
        CRF_ST_ERR  = 2'b10,
        CRF_ST_OFF  = 2'b11
    } crf_bus_state_t;

    // status change sensitivity levels
    typedef enum logic [1:0] {
        CRF_SENS_NONE   = 2'b00,
        CRF_SENS_BUSOFF = 2'b01,
        CRF_SENS_ERR    = 2'b10,
        CRF_SENS_ALL    = 2'b11
    } crf_sens_t;

endpackage

/* File: rtl/crf_state_track.sv */
`timescale 1ns/100ps
`default_nettype none
`include "crf_cfg.svh"

module crf_state_track
(
    // clock and reset
    input  wire logic                    mclk_in,
    input  wire logic                    resetn_in,
    // live state, sensitivity and blocking
    input  wire crf_pkg::crf_bus_state_t actual_in,
    input  wire crf_pkg::crf_sens_t      sens_in,
    input  wire logic                    hold_in,
    // reported state and status change request
    output var  crf_pkg::crf_bus_state_t state_out,
    output var  logic                    raise_out
);

    crf_pkg::crf_bus_state_t next_state;
    logic                    changed;
    logic                    hit;

    always_comb
    begin
        changed = (actual_in != state_out) && !hold_in;
        case (sens_in)
            crf_pkg::CRF_SENS_BUSOFF:
                hit = (state_out == crf_pkg::CRF_ST_OFF) != (actual_in == crf_pkg::CRF_ST_OFF);
            crf_pkg::CRF_SENS_ERR:
                hit = state_out[1] != actual_in[1];
            crf_pkg::CRF_SENS_ALL:
                hit = 1'b1;
            default:
                hit = 1'b0;
        endcase
        raise_out  = changed && hit;
        next_state = changed ? actual_in : state_out;
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_out <= crf_pkg::CRF_ST_OK;
        end
        else
        begin
            state_out <= next_state;
        end
    end

endmodule
`default_nettype wire

/* File: rtl/crf_sync2.sv */
`timescale 1ns/100ps
`default_nettype none
`include "crf_cfg.svh"

module crf_sync2
(
    // clock and reset
    input  wire logic mclk_in,
    input  wire logic resetn_in,
    // asynchronous level and its synchronised copy
    input  wire logic async_in,
    output var  logic sync_out
);

    logic stage1;
    logic next_stage1;
    logic next_sync;

    always_comb
    begin
        next_stage1 = async_in;
        next_sync   = stage1;
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            stage1   <= `CRF_PIN_RST;
            sync_out <= `CRF_PIN_RST;
        end
        else
        begin
            stage1   <= next_stage1;
            sync_out <= next_sync;
        end
    end

endmodule
`default_nettype wire

/* File: rtl/crf_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "crf_cfg.svh"

module crf_top
(
    // clock and reset
    input  wire logic                   mclk_in,
    input  wire logic                   resetn_in,
    // register port
    input  wire logic [`CRF_ADDR_W-1:0] addr_in,
    input  wire logic [`CRF_DATA_W-1:0] wdata_in,
    input  wire logic                   wr_in,
    input  wire logic                   rd_in,
    output logic      [`CRF_DATA_W-1:0] rdata_out,
    // controller mode
    input  wire logic                   init_request_in,
    input  wire logic                   init_acknowledge_in,
    input  wire logic                   sleep_active_in,
    input  wire logic                   wake_enable_in,
    // can bus receive pin
    input  wire logic                   can_rx_in,
    // error counters
    input  wire logic [8:0]             tx_err_count_in,
    input  wire logic [7:0]             rx_err_count_in,
    // receive fifo
    input  wire logic                   fifo_pending_in,
    input  wire logic                   overrun_in,
    output logic                        fg_shift_out,
    // interrupt requests
    output logic                        wake_irq_out,
    output logic                        err_irq_out,
    output logic                        rx_irq_out
);

    logic                    init_mode;
    logic                    rx_sync;
    logic                    rx_prev;
    logic                    next_rx_prev;
    logic                    tx_off_prev;
    logic                    next_tx_off_prev;
    logic                    tx_off_now;
    crf_pkg::crf_bus_state_t rx_act;
    crf_pkg::crf_bus_state_t tx_act;
    crf_pkg::crf_bus_state_t rx_rep;
    crf_pkg::crf_bus_state_t tx_rep;
    logic                    rx_raise;
    logic                    tx_raise;
    logic                    csc_hold;

    logic                    wake_flag;
    logic                    bus_state_change_flag;
    logic                    overrun_flag;
    logic                    rx_full_flag;
    logic [`CRF_DATA_W-1:0]  irq_en;
    logic                    next_wake_flag;
    logic                    next_csc_flag;
    logic                    next_overrun_flag;
    logic                    next_rx_full_flag;
    logic [`CRF_DATA_W-1:0]  next_irq_en;
    logic                    next_fg_shift;
    logic                    next_wake_irq;
    logic                    next_err_irq;
    logic                    next_rx_irq;
    logic [`CRF_DATA_W-1:0]  next_rdata;

    logic                    wr_flags;
    logic                    wr_irq_en;
    logic                    set_wake;
    logic                    set_csc;
    logic                    set_ovr;
    logic                    set_rxf;
    logic [`CRF_DATA_W-1:0]  flags_view;

    // mode decode
    always_comb
    begin
        init_mode = init_request_in && init_acknowledge_in;
    end

    // receive pin synchroniser
    crf_sync2 u_rx_sync
    (
        .mclk_in   (mclk_in),
        .resetn_in (resetn_in),
        .async_in  (can_rx_in),
        .sync_out  (rx_sync)
    );

    // live bus state from the error counters
    always_comb
    begin
        tx_off_now = tx_err_count_in > `CRF_TEC_OFF;
        if (tx_off_now)
        begin
            tx_act = crf_pkg::CRF_ST_OFF;
        end
        else if (tx_err_count_in > `CRF_TEC_ERR)
        begin
            tx_act = crf_pkg::CRF_ST_ERR;
        end
        else if (tx_err_count_in > `CRF_TEC_WARN)
        begin
            tx_act = crf_pkg::CRF_ST_WARN;
        end
        else
        begin
            tx_act = crf_pkg::CRF_ST_OK;
        end
        if (tx_off_now)
        begin
            rx_act = crf_pkg::CRF_ST_OFF;
        end
        else if (tx_off_prev)
        begin
            rx_act = crf_pkg::CRF_ST_OK;
        end
        else if (rx_err_count_in > `CRF_REC_ERR)
        begin
            rx_act = crf_pkg::CRF_ST_ERR;
        end
        else if (rx_err_count_in > `CRF_REC_WARN)
        begin
            rx_act = crf_pkg::CRF_ST_WARN;
        end
        else
        begin
            rx_act = crf_pkg::CRF_ST_OK;
        end
        csc_hold = bus_state_change_flag;
    end

    // reported fields, untouched by initialization mode
    crf_state_track u_rx_track
    (
        .mclk_in   (mclk_in),
        .resetn_in (resetn_in),
        .actual_in (rx_act),
        .sens_in   (crf_pkg::crf_sens_t'(irq_en[`CRF_RX_BUS_STATE_HI:`CRF_RX_BUS_STATE_LO])),
        .hold_in   (csc_hold),
        .state_out (rx_rep),
        .raise_out (rx_raise)
    );

    crf_state_track u_tx_track
    (
        .mclk_in   (mclk_in),
        .resetn_in (resetn_in),
        .actual_in (tx_act),
        .sens_in   (crf_pkg::crf_sens_t'(irq_en[`CRF_TX_BUS_STATE_HI:`CRF_TX_BUS_STATE_LO])),
        .hold_in   (csc_hold),
        .state_out (tx_rep),
        .raise_out (tx_raise)
    );

    // flag, enable and request next values
    always_comb
    begin
        wr_flags  = wr_in && (addr_in == `CRF_OFS_RX_FLAGS) && !init_mode;
        wr_irq_en = wr_in && (addr_in == `CRF_OFS_RX_IRQ_EN) && !init_mode;
        next_rx_prev     = rx_sync;
        next_tx_off_prev = tx_off_now;

        set_wake = sleep_active_in && wake_enable_in && rx_prev && !rx_sync;
        set_csc  = rx_raise || tx_raise;
        set_ovr  = overrun_in;
        next_fg_shift = fifo_pending_in && !rx_full_flag && !init_mode;
        set_rxf  = next_fg_shift;

        // set wins over a write clear in the same cycle; init mode clears over both
        if (set_wake)
        begin
            next_wake_flag = 1'b1;
        end
        else if (wr_flags && wdata_in[`CRF_BIT_WAKE])
        begin
            next_wake_flag = 1'b0;
        end
        else
        begin
            next_wake_flag = wake_flag;
        end
        if (set_csc)
        begin
            next_csc_flag = 1'b1;
        end
        else if (wr_flags && wdata_in[`CRF_BIT_CSC])
        begin
            next_csc_flag = 1'b0;
        end
        else
        begin
            next_csc_flag = bus_state_change_flag;
        end
        if (set_ovr)
        begin
            next_overrun_flag = 1'b1;
        end
        else if (wr_flags && wdata_in[`CRF_BIT_OVR])
        begin
            next_overrun_flag = 1'b0;
        end
        else
        begin
            next_overrun_flag = overrun_flag;
        end
        if (set_rxf)
        begin
            next_rx_full_flag = 1'b1;
        end
        else if (wr_flags && wdata_in[`CRF_BIT_RXF])
        begin
            next_rx_full_flag = 1'b0;
        end
        else
        begin
            next_rx_full_flag = rx_full_flag;
        end
        next_irq_en = wr_irq_en ? wdata_in : irq_en;

        if (init_mode)
        begin
            next_wake_flag    = 1'b0;
            next_csc_flag     = 1'b0;
            next_overrun_flag = 1'b0;
            next_rx_full_flag = 1'b0;
            next_irq_en       = `CRF_IRQ_EN_RST;
        end

        next_wake_irq = next_wake_flag && next_irq_en[`CRF_BIT_WAKE];
        next_err_irq  = (next_csc_flag && next_irq_en[`CRF_BIT_CSC]) ||
                        (next_overrun_flag && next_irq_en[`CRF_BIT_OVR]);
        next_rx_irq   = next_rx_full_flag && next_irq_en[`CRF_BIT_RXF];
    end

    // read path, no side effects
    always_comb
    begin
        flags_view = {wake_flag, bus_state_change_flag, rx_rep, tx_rep,
                      overrun_flag, rx_full_flag};
        if (!rd_in)
        begin
            next_rdata = `CRF_RDATA_RST;
        end
        else if (addr_in == `CRF_OFS_RX_FLAGS)
        begin
            next_rdata = flags_view;
        end
        else if (addr_in == `CRF_OFS_RX_IRQ_EN)
        begin
            next_rdata = irq_en;
        end
        else if (addr_in == `CRF_OFS_LIVE_STATE)
        begin
            next_rdata = {init_mode, 3'h0, rx_act, tx_act};
        end
        else
        begin
            next_rdata = `CRF_RDATA_RST;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rx_prev               <= `CRF_PIN_RST;
            tx_off_prev           <= 1'b0;
            wake_flag             <= 1'b0;
            bus_state_change_flag <= 1'b0;
            overrun_flag          <= 1'b0;
            rx_full_flag          <= 1'b0;
            irq_en                <= `CRF_IRQ_EN_RST;
            fg_shift_out          <= 1'b0;
            wake_irq_out          <= 1'b0;
            err_irq_out           <= 1'b0;
            rx_irq_out            <= 1'b0;
            rdata_out             <= `CRF_RDATA_RST;
        end
        else
        begin
            rx_prev               <= next_rx_prev;
            tx_off_prev           <= next_tx_off_prev;
            wake_flag             <= next_wake_flag;
            bus_state_change_flag <= next_csc_flag;
            overrun_flag          <= next_overrun_flag;
            rx_full_flag          <= next_rx_full_flag;
            irq_en                <= next_irq_en;
            fg_shift_out          <= next_fg_shift;
            wake_irq_out          <= next_wake_irq;
            err_irq_out           <= next_err_irq;
            rx_irq_out            <= next_rx_irq;
            rdata_out             <= next_rdata;
        end
    end

endmodule
`default_nettype wire

/* File: verification/crf_can_node_model.sv */
`timescale 1ns/100ps
`default_nettype none
module crf_can_node_model
(
    // clock and reset
    input  wire logic mclk_in,
    input  wire logic resetn_in,
    // commands from the bench
    input  wire logic send_in,
    input  wire logic wake_in,
    // receive fifo side
    input  wire logic fg_shift_in,
    output var  logic fifo_pending_out,
    // bus pin
    output var  logic can_rx_out
);
    logic [3:0] queued;
    logic [2:0] dom_left;
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            queued   <= 4'h0;
            dom_left <= 3'h0;
        end
        else
        begin
            queued   <= queued + {3'h0, send_in} - {3'h0, fg_shift_in};
            dom_left <= wake_in ? 3'h4 : dom_left - {2'h0, |dom_left};
        end
    end
    // an entry waits until the block shifts it out
    assign fifo_pending_out = |queued;
    // recessive high outside the short dominant burst
    assign can_rx_out = ~|dom_left;
endmodule
`default_nettype wire

/* File: verification/crf_top_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module crf_top_bench;
    logic       mclk_in = 1'b0;
    logic       resetn_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic       wr_in = 1'b0;
    logic       rd_in = 1'b0;
    logic       init_request_in = 1'b0;
    logic       init_acknowledge_in = 1'b0;
    logic       sleep_active_in = 1'b0;
    logic       wake_enable_in = 1'b0;
    logic [8:0] tx_err_count_in = 9'h000;
    logic [7:0] rx_err_count_in = 8'h00;
    logic       overrun_in = 1'b0;
    logic       send = 1'b0;
    logic       wake = 1'b0;
    wire logic  can_rx, fifo_pending, fg_shift, wake_irq, err_irq, rx_irq;
    wire logic  [7:0] rdata;
    int         err_total = 0;
    int         check_count = 0;
    int         cycles = 0;
    // bus state steps: counts, clear after read, expected flags
    logic [7:0] t_rec [7] = '{8'h61, 8'h80, 8'h80, 8'h00, 8'h80, 8'h80, 8'h00};
    logic [8:0] t_tec [7] = '{9'h000, 9'h000, 9'h000, 9'h100, 9'h000, 9'h000, 9'h061};
    logic       t_clr [7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [7:0] t_exp [7] = '{8'h50, 8'h50, 8'h60, 8'h7C, 8'h40, 8'h60, 8'h44};

    crf_top i_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
        .init_request_in(init_request_in), .init_acknowledge_in(init_acknowledge_in),
        .sleep_active_in(sleep_active_in), .wake_enable_in(wake_enable_in),
        .can_rx_in(can_rx), .tx_err_count_in(tx_err_count_in),
        .rx_err_count_in(rx_err_count_in), .fifo_pending_in(fifo_pending),
        .overrun_in(overrun_in), .fg_shift_out(fg_shift), .wake_irq_out(wake_irq),
        .err_irq_out(err_irq), .rx_irq_out(rx_irq));
    crf_can_node_model i_node (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .send_in(send), .wake_in(wake), .fg_shift_in(fg_shift),
        .fifo_pending_out(fifo_pending), .can_rx_out(can_rx));

    initial
    begin
        forever #25 mclk_in = ~mclk_in;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge mclk_in);
        wr_in    <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] want);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge mclk_in);
        rd_in   <= 1'b0;
        @(negedge mclk_in);
        check(rdata, want);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic pulse_send;
        @(posedge mclk_in);
        send <= 1'b1;
        @(posedge mclk_in);
        send <= 1'b0;
    endtask
    task automatic pulse_wake;
        @(posedge mclk_in);
        wake <= 1'b1;
        @(posedge mclk_in);
        wake <= 1'b0;
        idle(8);
    endtask
    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            summarize();
        end
    end

    initial
    begin
        idle(4);
        resetn_in <= 1'b1;
        rdchk(4'h0, 8'h00);
        rdchk(4'hF, 8'h00);
        wr(4'h1, 8'hFF);
        rdchk(4'h1, 8'hFF);
        $display("test reset and enables done");
        pulse_send();
        pulse_send();
        idle(3);
        rdchk(4'h0, 8'h01);
        check({7'h00, rx_irq}, 8'h01);
        check({7'h00, fifo_pending}, 8'h01);
        wr(4'h0, 8'h00);
        rdchk(4'h0, 8'h01);
        wr(4'h0, 8'h01);
        idle(3);
        rdchk(4'h0, 8'h01);
        check({7'h00, fifo_pending}, 8'h00);
        wr(4'h0, 8'h01);
        idle(3);
        rdchk(4'h0, 8'h00);
        check({7'h00, rx_irq}, 8'h00);
        $display("test receive full done");
        @(posedge mclk_in);
        overrun_in <= 1'b1;
        @(posedge mclk_in);
        overrun_in <= 1'b0;
        rdchk(4'h0, 8'h02);
        check({7'h00, err_irq}, 8'h01);
        wr(4'h0, 8'h3E);
        rdchk(4'h0, 8'h00);
        $display("test overrun done");
        @(posedge mclk_in);
        sleep_active_in <= 1'b1;
        pulse_wake();
        rdchk(4'h0, 8'h00);
        @(posedge mclk_in);
        wake_enable_in <= 1'b1;
        pulse_wake();
        rdchk(4'h0, 8'h80);
        check({7'h00, wake_irq}, 8'h01);
        wr(4'h0, 8'h80);
        rdchk(4'h0, 8'h00);
        @(posedge mclk_in);
        sleep_active_in <= 1'b0;
        $display("test wake done");
        for (int i = 0; i < 7; i++)
        begin
            @(posedge mclk_in);
            rx_err_count_in <= t_rec[i];
            tx_err_count_in <= t_tec[i];
            idle(4);
            rdchk(4'h0, t_exp[i]);
            if (t_clr[i])
                wr(4'h0, 8'h40);
        end
        check({7'h00, err_irq}, 8'h01);
        $display("test bus state done");
        @(posedge mclk_in);
        init_request_in <= 1'b1;
        wr(4'h1, 8'h01);
        rdchk(4'h1, 8'h01);
        @(posedge mclk_in);
        init_acknowledge_in <= 1'b1;
        idle(2);
        rdchk(4'h0, 8'h04);
        rdchk(4'h2, 8'h81);
        @(posedge mclk_in);
        tx_err_count_in <= 9'h000;
        idle(3);
        rdchk(4'h0, 8'h00);
        wr(4'h1, 8'hFF);
        rdchk(4'h1, 8'h00);
        @(posedge mclk_in);
        init_request_in     <= 1'b0;
        init_acknowledge_in <= 1'b0;
        wr(4'h1, 8'h02);
        rdchk(4'h1, 8'h02);
        $display("test init mode done");
        wr(4'h1, 8'h14);
        @(posedge mclk_in);
        rx_err_count_in <= 8'h80;
        tx_err_count_in <= 9'h080;
        idle(4);
        rdchk(4'h0, 8'h28);
        @(posedge mclk_in);
        tx_err_count_in <= 9'h100;
        idle(4);
        rdchk(4'h0, 8'h7C);
        check({7'h00, err_irq}, 8'h00);
        wr(4'h0, 8'h40);
        wr(4'h1, 8'h28);
        @(posedge mclk_in);
        tx_err_count_in <= 9'h080;
        idle(4);
        rdchk(4'h0, 8'h48);
        $display("test sensitivity done");
        summarize();
    end
endmodule
`default_nettype wire

/* File: verification/crf_top_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module crf_top_monitor
(
    // clock and reset
    input wire logic       mclk_in,
    input wire logic       resetn_in,
    // register port
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    // mode, bus and fifo
    input wire logic       init_request_in,
    input wire logic       init_acknowledge_in,
    input wire logic       sleep_active_in,
    input wire logic       wake_enable_in,
    input wire logic       can_rx_in,
    input wire logic [8:0] tx_err_count_in,
    input wire logic [7:0] rx_err_count_in,
    input wire logic       fifo_pending_in,
    input wire logic       overrun_in,
    input wire logic       fg_shift_out,
    // requests
    input wire logic       wake_irq_out,
    input wire logic       err_irq_out,
    input wire logic       rx_irq_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    logic init_mode;
    assign init_mode = init_request_in && init_acknowledge_in;

    AST_RDATA_IDLE: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data not zero outside a read answer");
    AST_RD_UNMAPPED: assert property (rd_in && addr_in > 4'h2 |=> rdata_out == 8'h00)
        else $error("unmapped read returned data");
    AST_SHIFT_PULSE: assert property (fg_shift_out |=> !fg_shift_out)
        else $error("foreground shift in two cycles running");
    AST_SHIFT_CAUSE: assert property (fg_shift_out |-> $past(fifo_pending_in) && !$past(init_mode))
        else $error("shift without pending message or during init");
    AST_INIT_QUIET: assert property (init_mode |=> !wake_irq_out && !err_irq_out && !rx_irq_out && !fg_shift_out)
        else $error("activity while init mode holds the flags");
    AST_INIT_FLAGS_READ: assert property (init_mode && $past(init_mode) && rd_in && addr_in == 4'h0 |=> (rdata_out & 8'hC3) == 8'h00)
        else $error("flag bits not cleared in init mode");
    AST_RX_IRQ_HOLD: assert property (rx_irq_out && !wr_in && !init_mode |=> rx_irq_out)
        else $error("receive request dropped without a write");
    AST_ERR_IRQ_HOLD: assert property (err_irq_out && !wr_in && !init_mode |=> err_irq_out)
        else $error("error request dropped without a write");
    AST_WAKE_IRQ_HOLD: assert property (wake_irq_out && !wr_in && !init_mode |=> wake_irq_out)
        else $error("wake request dropped without a write");
    AST_RX_IRQ_RISE: assert property ($rose(rx_irq_out) |-> fg_shift_out || $past(wr_in && addr_in == 4'h1))
        else $error("receive request rose without a shift");
    AST_WAKE_RISE: assert property ($rose(wake_irq_out) |-> $past(sleep_active_in && wake_enable_in) || $past(wr_in && addr_in == 4'h1))
        else $error("wake request rose outside enabled sleep");

    cover property (fg_shift_out);
    cover property ($rose(err_irq_out));
    cover property ($rose(wake_irq_out));
endmodule

bind crf_top crf_top_monitor i_monitor (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .init_request_in(init_request_in),
    .init_acknowledge_in(init_acknowledge_in), .sleep_active_in(sleep_active_in),
    .wake_enable_in(wake_enable_in), .can_rx_in(can_rx_in),
    .tx_err_count_in(tx_err_count_in), .rx_err_count_in(rx_err_count_in),
    .fifo_pending_in(fifo_pending_in), .overrun_in(overrun_in),
    .fg_shift_out(fg_shift_out), .wake_irq_out(wake_irq_out),
    .err_irq_out(err_irq_out), .rx_irq_out(rx_irq_out));
`default_nettype wire
